/* include/flash_pin_pkg.sv */
// Constants and types shared by the serial flash pin front end.
// Assumes a single system clock that oversamples the host serial clock.
package flash_pin_pkg;
   // Shape of a serial byte and of the bit counters.
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] RX_LAST_BIT = 3'h7;
   localparam logic [3:0] TX_FULL_BITS = 4'h8;
   localparam logic [3:0] TX_STEP_SINGLE = 4'h1;
   localparam logic [3:0] TX_STEP_DUAL = 4'h2;
   // Values after reset, and the receive buffer depth.
   localparam logic [2:0] SYNC_RESET = 3'h0;
   localparam logic PIN_RESET = 1'h0;
   localparam logic [1:0] BUF_COUNT_RESET = 2'h0;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   // Select state of the device.
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b01,
      ST_SELECTED = 2'b10
   } sel_state_t;
endpackage

/* hdl/flash_spi_front.sv */
// Pin front end of a serial flash: select, serial clock, input line and
// the two data lines, with a two-entry receive buffer toward the core.
// Assumes the host serial clock is much slower than clock_i (oversampled).
//
// How it works
// RL1 - Serial clock may idle low or high.
// RL2 - Select released means standby, not power-down.
// RL3 - Operation starts only after select falls.
// RL4 - Input bits sampled on serial clock rise.
// RL5 - Host keeps input stable around rising edge.
// RL6 - Output changes only on serial clock fall.
// RL7 - Dual read drives both lines, two bits.
// RL8 - Input line ignored while deselected.
// RL9 - Output lines released while deselected.
// RL10 - Deselect drops partial bytes, clears counter.
module flash_spi_front (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_i,
   // Host pins.
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic dual_line_low_i,
   output logic dual_line_low_o,
   output logic dual_line_low_oe_o,
   output logic dual_line_high_o,
   output logic dual_line_high_oe_o,
   // Received bytes toward the core.
   output logic [flash_pin_pkg::BYTE_BITS-1:0] rx_data_o,
   output logic rx_first_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic rx_overrun_o,
   // Bytes to send from the core.
   input wire logic [flash_pin_pkg::BYTE_BITS-1:0] tx_data_i,
   input wire logic tx_dual_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // Select status.
   output logic selected_o
);
   import flash_pin_pkg::*;

   typedef struct packed {
      sel_state_t fsm;
      logic [2:0] cs_s;
      logic [2:0] sck_s;
      logic [2:0] si_s;
      logic cs_f;
      logic sck_f;
      logic si_f;
      logic [7:0] rx_sh;
      logic [2:0] rx_cnt;
      logic rx_first;
      logic overrun;
      logic [1:0][7:0] buf_data;
      logic [1:0] buf_first;
      logic [1:0] buf_cnt;
      logic [7:0] tx_sh;
      logic [3:0] tx_left;
      logic tx_dual;
      logic high_out;
      logic low_out;
      logic high_oe;
      logic low_oe;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic cs_new;
   logic sck_new;
   logic si_new;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;

   // A pin level counts once the second and third stages agree.
   function automatic logic agreed(input logic [2:0] s, input logic held);
      agreed = (s[1] == s[2]) ? s[2] : held;
   endfunction

   // Filtered pin levels and their edges.
   // RL1 - either idle level
   always_comb begin
      cs_new = agreed(state_reg.cs_s, state_reg.cs_f);
      sck_new = agreed(state_reg.sck_s, state_reg.sck_f);
      si_new = agreed(state_reg.si_s, state_reg.si_f);
      cs_fall = state_reg.cs_f && !cs_new;
      cs_rise = !state_reg.cs_f && cs_new;
      sck_rise = !state_reg.sck_f && sck_new;
      sck_fall = state_reg.sck_f && !sck_new;
   end

   // Handshake outputs are combinational; data comes from flip-flops.
   always_comb begin
      rx_valid_o = (state_reg.buf_cnt != BUF_COUNT_RESET);
      rx_data_o = state_reg.buf_data[0];
      rx_first_o = state_reg.buf_first[0];
      tx_ready_o = (state_reg.fsm == ST_SELECTED) && (state_reg.tx_left == 4'h0);
      selected_o = (state_reg.fsm == ST_SELECTED);
      rx_overrun_o = state_reg.overrun;
      dual_line_high_o = state_reg.high_out;
      dual_line_low_o = state_reg.low_out;
      dual_line_high_oe_o = state_reg.high_oe;
      dual_line_low_oe_o = state_reg.low_oe;
   end

   // Next-state logic for synchronisers, select, receive and transmit paths.
   always_comb begin
      logic [7:0] byte_in;
      logic [1:0] cnt;
      byte_in = {state_reg.rx_sh[6:0], si_new};
      cnt = state_reg.buf_cnt;
      state_next = state_reg;
      // Only the second stage reads the first one.
      state_next.cs_s = {state_reg.cs_s[1:0], cs_n_i};
      state_next.sck_s = {state_reg.sck_s[1:0], sck_i};
      state_next.si_s = {state_reg.si_s[1:0], dual_line_low_i};
      state_next.cs_f = cs_new;
      state_next.sck_f = sck_new;
      state_next.si_f = si_new;

      // Buffer pop first, so a push in the same cycle lands behind it.
      if (rx_valid_o && rx_ready_i) begin
         state_next.buf_data[0] = state_reg.buf_data[1];
         state_next.buf_first[0] = state_reg.buf_first[1];
         cnt = cnt - 2'h1;
      end

      unique case (state_reg.fsm)
         ST_STANDBY: begin
            // RL8 - no input shift
            // RL3 - falling select starts
            if (cs_fall) begin
               state_next.fsm = ST_SELECTED;
               state_next.rx_cnt = 3'h0;
               state_next.rx_first = 1'b1;
               state_next.overrun = 1'b0;
            end
         end
         ST_SELECTED: begin
            if (cs_rise) begin
               // RL2 - back to standby
               state_next.fsm = ST_STANDBY;
               // RL10 - drop partial bits
               state_next.rx_cnt = 3'h0;
               state_next.rx_sh = 8'h00;
               state_next.tx_left = 4'h0;
               // RL9 - release output lines
               state_next.high_oe = 1'b0;
               state_next.low_oe = 1'b0;
            end else begin
               // RL4 - sample on rise; the input line is ignored while it drives.
               if (sck_rise && !state_reg.low_oe) begin
                  state_next.rx_sh = byte_in;
                  state_next.rx_cnt = state_reg.rx_cnt + 3'h1;
                  if (state_reg.rx_cnt == RX_LAST_BIT) begin
                     state_next.rx_first = 1'b0;
                     // A third byte with both entries taken is lost and flagged.
                     if (cnt == BUF_DEPTH) begin
                        state_next.overrun = 1'b1;
                     end else begin
                        state_next.buf_data[cnt[0]] = byte_in;
                        state_next.buf_first[cnt[0]] = state_reg.rx_first;
                        cnt = cnt + 2'h1;
                     end
                  end
               end
               // Load a new byte once the previous one is fully shifted out.
               if (tx_valid_i && tx_ready_o) begin
                  state_next.tx_sh = tx_data_i;
                  state_next.tx_left = TX_FULL_BITS;
                  state_next.tx_dual = tx_dual_i;
               end
               // RL6 - drive on fall
               if (sck_fall && state_reg.tx_left != 4'h0) begin
                  state_next.high_out = state_reg.tx_sh[7];
                  state_next.high_oe = 1'b1;
                  if (state_reg.tx_dual) begin
                     // RL7 - two bits per fall
                     state_next.low_out = state_reg.tx_sh[6];
                     state_next.low_oe = 1'b1;
                     state_next.tx_sh = {state_reg.tx_sh[5:0], 2'b00};
                     state_next.tx_left = state_reg.tx_left - TX_STEP_DUAL;
                  end else begin
                     state_next.low_oe = 1'b0;
                     state_next.tx_sh = {state_reg.tx_sh[6:0], 1'b0};
                     state_next.tx_left = state_reg.tx_left - TX_STEP_SINGLE;
                  end
               end
            end
         end
      endcase
      state_next.buf_cnt = cnt;
   end

   // Single register for all state; select filter resets low so a select
   // held low through reset must first rise before an operation may start.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_reg <= '0;
         state_reg.fsm <= ST_STANDBY;
         state_reg.cs_s <= SYNC_RESET;
         state_reg.cs_f <= PIN_RESET;
         state_reg.buf_cnt <= BUF_COUNT_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // RL9 - no drive when deselected
   AST_DESELECT_HIZ: assert property (@(posedge clock_i) disable iff (rst_i) // RL9
      (state_reg.fsm == ST_STANDBY) |-> !dual_line_high_oe_o && !dual_line_low_oe_o)
      else $error("Output driven while deselected.");

   // RL3 - selection follows a falling edge
   AST_SELECT_NEEDS_FALL: assert property (@(posedge clock_i) disable iff (rst_i) // RL3
      $rose(selected_o) |-> $past(state_reg.cs_f) && !state_reg.cs_f)
      else $error("Selected without a select falling edge.");

   // RL2 - standby one cycle after release
   AST_STANDBY_ON_RELEASE: assert property (@(posedge clock_i) disable iff (rst_i) // RL2
      (selected_o && cs_rise) |=> !selected_o && state_reg.fsm == ST_STANDBY)
      else $error("Select release did not return to standby.");

   // RL4 - every rise while selected shifts in a receive bit unless select is released in that cycle or the input line is being driven
   AST_SAMPLE_ON_RISE: assert property (@(posedge clock_i) disable iff (rst_i) // RL4
      (selected_o && !cs_rise && sck_rise && !dual_line_low_oe_o)
      |=> state_reg.rx_sh[0] == $past(si_new) && state_reg.rx_cnt == $past(state_reg.rx_cnt) + 3'h1)
      else $error("Input bit not taken on serial clock rise.");

   // RL6 - output moves only on falls
   AST_OUT_ON_FALL: assert property (@(posedge clock_i) disable iff (rst_i) // RL6
      $changed(dual_line_high_o) |-> $past(sck_fall))
      else $error("Output line changed without a falling edge.");

   // RL7 - dual drive implies both lines
   AST_DUAL_BOTH_LINES: assert property (@(posedge clock_i) disable iff (rst_i) // RL7
      dual_line_low_oe_o |-> dual_line_high_oe_o && $past(state_reg.tx_dual))
      else $error("Dual drive without the second line.");

   // RL8 - input ignored while deselected
   AST_IGNORE_WHEN_IDLE: assert property (@(posedge clock_i) disable iff (rst_i) // RL8
      (state_reg.fsm == ST_STANDBY) ##1 (state_reg.fsm == ST_STANDBY)
      |-> $stable(state_reg.rx_cnt) && $stable(state_reg.rx_sh))
      else $error("Input accepted while deselected.");

   // RL10 - counter cleared on release
   AST_COUNT_CLEARED: assert property (@(posedge clock_i) disable iff (rst_i) // RL10
      (selected_o && cs_rise) |=> (state_reg.rx_cnt == 3'h0 && state_reg.tx_left == 4'h0) [*2])
      else $error("Bit counter not cleared on deselect.");

   // RL1 - a fall moves no receive bit
   AST_FALL_KEEPS_COUNT: assert property (@(posedge clock_i) disable iff (rst_i) // RL1
      (sck_fall && !sck_rise) |=> $stable(state_reg.rx_cnt) || !selected_o)
      else $error("Receive counter moved on a falling edge.");
endmodule

/* sim/host_spi_model.sv */
// Host serial controller model: select, serial clock and the input line.
// Assumes clock_i oversamples the link; a link half period is four cycles.
module host_spi_model (
   // Clock.
   input wire logic clock_i,
   // Link pins.
   output logic cs_n_o = 1'b1,
   output logic sck_o = 1'b0,
   output logic mosi_o = 1'b0,
   output logic mosi_oe_o = 1'b1,
   input wire logic hi_i,
   input wire logic lo_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic idle_high = 1'b0;
   // One link half period.
   task automatic half();
      repeat (4) @(posedge clock_i);
   endtask
   task automatic select(input logic mode3);
      idle_high = mode3;
      sck_o <= mode3;
      half();
      cs_n_o <= 1'b0;
      half();
   endtask
   task automatic deselect();
      sck_o <= idle_high;
      half();
      cs_n_o <= 1'b1;
      half();
      // The select filter needs four cycles; wait on so standby has settled.
      half();
   endtask
   // change at fall, release
   // Read data is taken late in the high phase, as the front end answers cycles after a fall.
   task automatic xfer(input logic [7:0] tx, input int nbits, input logic dual, output logic [7:0] rx);
      rx = 8'h00;
      // Only a dual transfer touches the enable, so back to back calls never drive it twice.
      if (dual) mosi_oe_o <= 1'b0;
      for (int i = 0; i <= nbits; i += dual ? 2 : 1) begin
         if (i > 0) rx = dual ? {rx[5:0], hi_i, lo_i} : {rx[6:0], hi_i};
         if (i < nbits) begin
            sck_o <= 1'b0;
            mosi_o <= tx[7 - i];
            half();
            sck_o <= 1'b1;
            half();
         end
      end
      if (dual) mosi_oe_o <= 1'b1;
   endtask
endmodule

/* sim/tb_top.sv */
// Testbench for the flash pin front end with a host model on the link.
// Assumes the host model answers tasks called from the main sequence.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0, rst_i = 1'b1, rx_ready_i = 1'b0, tx_dual_i = 1'b0, tx_valid_i = 1'b0;
   logic stall = 1'b1, hi_last = 1'b0, lo_last = 1'b0;
   logic [7:0] tx_data_i = 8'h00, rx_data_o, got, b;
   logic cs_n, sck, mosi, mosi_oe, lo_o, lo_oe, hi_o, hi_oe, rx_first_o, rx_valid_o, rx_overrun_o;
   logic tx_ready_o, selected_o;
   int mismatches = 0, n_checks = 0;
   logic [8:0] exp_q[$];
   // Released lines carry no stale value, so they toggle.
   wire logic lo_w = lo_oe ? lo_o : (mosi_oe ? mosi : ~lo_last);
   wire logic hi_w = hi_oe ? hi_o : ~hi_last;
   wire logic [8:0] stat = {3'h0, rx_overrun_o, tx_ready_o, selected_o, hi_oe, lo_oe, rx_valid_o};
   initial forever #12.5 clock_i = ~clock_i;
   // Line history and a random receive stall.
   always @(posedge clock_i) begin
      hi_last <= hi_w;
      lo_last <= lo_w;
      rx_ready_i <= !stall && 1'($urandom % 2);
   end
   host_spi_model host_spi_model_i (.clock_i(clock_i), .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi),
      .mosi_oe_o(mosi_oe), .hi_i(hi_w), .lo_i(lo_w));
   flash_spi_front flash_spi_front_i (.clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck),
      .dual_line_low_i(lo_w), .dual_line_low_o(lo_o), .dual_line_low_oe_o(lo_oe), .dual_line_high_o(hi_o),
      .dual_line_high_oe_o(hi_oe), .rx_data_o(rx_data_o), .rx_first_o(rx_first_o), .rx_valid_o(rx_valid_o),
      .rx_ready_i(rx_ready_i), .rx_overrun_o(rx_overrun_o), .tx_data_i(tx_data_i), .tx_dual_i(tx_dual_i),
      .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .selected_o(selected_o));
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic give_up(input string what);
      mismatches++;
      $display("[FAIL] %s expected done seen pending", what);
      final_report();
   endtask
   // Each popped byte is compared with the oldest note; a byte with no note is a fault.
   always @(posedge clock_i) begin
      if (!rst_i && rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected byte", {rx_first_o, rx_data_o}, 9'hxxx);
         else check("rx byte", {rx_first_o, rx_data_o}, exp_q.pop_front());
      end
   end
   task automatic write_bytes(input logic mode3, input int n);
      host_spi_model_i.select(mode3);
      for (int k = 0; k < n; k++) begin
         b = 8'($urandom);
         exp_q.push_back({k == 0, b});
         host_spi_model_i.xfer(b, 8, 1'b0, got);
      end
      host_spi_model_i.deselect();
   endtask
   task automatic wait_empty();
      for (int i = 0; i < 400; i++) begin
         if (exp_q.size() == 0 && rx_valid_o === 1'b0) return;
         @(posedge clock_i);
      end
      give_up("drain");
   endtask
   task automatic read_byte(input logic dual);
      int i;
      host_spi_model_i.select(1'b1);
      for (i = 0; i < 40 && tx_ready_o !== 1'b1; i++) @(posedge clock_i);
      if (i == 40) give_up("tx ready");
      b = 8'($urandom);
      tx_data_i <= b;
      tx_dual_i <= dual;
      tx_valid_i <= 1'b1;
      @(posedge clock_i);
      tx_valid_i <= 1'b0;
      if (!dual) exp_q.push_back(9'h100);
      host_spi_model_i.xfer(8'h00, 8, dual, got);
      check("read data", {1'b0, got}, {1'b0, b});
      check("read status", stat & 9'h03e, {7'h07, dual, 1'b0});
      host_spi_model_i.deselect();
      check("released", stat & 9'h03e, 9'h000);
   endtask
   initial begin
      void'($urandom(32'h9c3ae351));
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      check("reset status", stat, 9'h000);
      stall <= 1'b0;
      write_bytes(1'b0, 3);
      write_bytes(1'b1, 3);
      wait_empty();
      $display("test write modes done");
      host_spi_model_i.xfer(8'($urandom), 8, 1'b0, got);
      check("deselected status", stat, 9'h000);
      host_spi_model_i.select(1'b0);
      host_spi_model_i.xfer(8'($urandom), 5, 1'b0, got);
      host_spi_model_i.deselect();
      write_bytes(1'b0, 1);
      wait_empty();
      $display("test deselect done");
      stall <= 1'b1;
      write_bytes(1'b1, 3);
      void'(exp_q.pop_back());
      check("overrun status", stat, 9'h021);
      stall <= 1'b0;
      wait_empty();
      $display("test overrun done");
      read_byte(1'b0);
      read_byte(1'b1);
      wait_empty();
      $display("test read done");
      final_report();
   end
   initial begin
      repeat (60000) @(posedge clock_i);
      give_up("run");
   end
endmodule
